// ### shared/cca_regs.svh
`ifndef CCA_REGS_SVH
`define CCA_REGS_SVH
// Register indices on the plain register port (8-bit data, 5-bit address).
// Nineteen registers need five index bits; four would fold capture highs 2 to 4 onto control, mode and counter low.
`define CCA_ADDR_CTRL   5'h00
`define CCA_ADDR_MODE   5'h01
`define CCA_ADDR_CNT_LO 5'h02
`define CCA_ADDR_CNT_HI 5'h03
`define CCA_ADDR_MMODE0 5'h04
`define CCA_ADDR_CAPLO0 5'h09
`define CCA_ADDR_CAPHI0 5'h0E
// Fields of the counter control register.
`define CCA_CTRL_OVF    7
`define CCA_CTRL_RUN    6
// Fields of the counter mode register.
`define CCA_MODE_WDOG   6
`define CCA_MODE_SEL_HI 2
`define CCA_MODE_SEL_LO 1
`define CCA_MODE_OVF_IE 0
// Fields of each module mode register.
`define CCA_MM_CMP      6
`define CCA_MM_RISE     5
`define CCA_MM_FALL     4
`define CCA_MM_MATCH    3
`define CCA_MM_TOG      2
`define CCA_MM_PWM      1
`define CCA_MM_IE       0
`define CCA_MM_MASK     8'h7F
`define CCA_MODE_MASK   8'h47
`define CCA_CTRL_MASK   8'hDF
`define CCA_RESET_BYTE  8'h00
`define CCA_BYTE_MAX    8'hFF
`define CCA_WDOG_MOD    4
// Count source encodings.
`define CCA_SRC_DIV6A   2'h0
`define CCA_SRC_DIV6B   2'h1
`define CCA_SRC_TIMER0  2'h2
`define CCA_SRC_EXT     2'h3
`define CCA_DIV6_LAST   3'h5
`endif

// ### shared/cca_pkg.sv
package cca_pkg;
  typedef logic [7:0] cca_byte_t;
  typedef enum logic [1:0] {CCA_IDLE, CCA_PULSE} cca_wdog_e;
endpackage : cca_pkg

// ### design/cca_edge_sync.sv
`timescale 1ns/1ps
`include "cca_regs.svh"
// Two-flop synchroniser with rise and fall pulses taken from the settled stages.
module cca_edge_sync #(
  parameter int WIDTH = 5
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  // Raw asynchronous levels.
  input  wire logic [WIDTH-1:0] async_in,
  // Synchronised level and edge pulses.
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  initial begin
    if (WIDTH < 1) $error("WIDTH must be at least one.");
  end

  // The first stage feeds only the second, so edges never see a metastable value.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges compare two settled stages.
  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule : cca_edge_sync

// ### design/cca_counter_array.sv
`timescale 1ns/1ps
`include "cca_regs.svh"
module cca_counter_array #(
  parameter int NMOD = 5
) (
  // Clock and reset.
  input  wire logic            clk_in,
  input  wire logic            resetn_in,
  // Register port; read data stands the cycle after the read strobe.
  input  wire logic [4:0]      addr_in,
  input  wire logic [7:0]      wdata_in,
  input  wire logic            write_in,
  input  wire logic            read_in,
  output logic      [7:0]      rdata_out,
  // Count sources.
  input  wire logic            timer0_ovf_in,
  input  wire logic            ext_count_in,
  // Module pins, as capture inputs or driven outputs.
  input  wire logic [NMOD-1:0] module_io_pin_in,
  output logic      [NMOD-1:0] module_io_pin_out,
  output logic      [NMOD-1:0] module_io_pin_oe_out,
  // System side.
  output logic                 irq_out,
  output logic                 wdog_reset_out
);
  logic [7:0]           cnt_lo_q;
  logic [7:0]           cnt_hi_q;
  logic                 ovf_flag_q;
  logic                 run_q;
  logic [NMOD-1:0]      ev_flag_q;
  logic [7:0]           mode_q;
  logic [7:0]           mmode_q  [NMOD];
  logic [7:0]           cap_lo_q [NMOD];
  logic [7:0]           cap_hi_q [NMOD];
  logic [NMOD-1:0]      pin_q;
  logic [NMOD-1:0]      oe_q;
  logic [7:0]           rdata_q;
  logic                 irq_q;
  logic                 wdog_q;
  logic [2:0]           div_q;
  logic [1:0]           src_sync_q;
  logic                 ext_meta_q;
  logic                 ext_sync_q;
  logic                 ext_prev_q;
  logic                 t0_prev_q;
  logic                 tick;
  logic                 lo_wrap;
  logic [NMOD-1:0]      pin_rise;
  logic [NMOD-1:0]      pin_fall;
  logic [NMOD-1:0]      cap_ev;
  logic [NMOD-1:0]      match_ev;
  logic [NMOD-1:0]      match_prev_q;
  cca_pkg::cca_wdog_e   wst_q;

  initial begin
    if (NMOD != 5) $error("NMOD must be 5: the register map holds five modules.");
  end

  // Index helpers for the per-module register blocks.
  function automatic logic hit(input logic [4:0] a, input logic [4:0] base, input int m);
    hit = (a == 5'(base + 5'(m)));
  endfunction : hit

  function automatic logic bit_of(input logic [7:0] v, input int b);
    bit_of = v[b];
  endfunction : bit_of

  // Pins pass two flops before edge detection.
  cca_edge_sync #(
    .WIDTH (NMOD)
  ) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .async_in  (module_io_pin_in),
    .level_out (),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  // External count source is synchronised; timer0 overflow is on-chip and same-clock.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      ext_prev_q <= 1'b0;
      t0_prev_q  <= 1'b0;
      div_q      <= 3'h0;
    end else begin
      ext_meta_q <= ext_count_in;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
      t0_prev_q  <= timer0_ovf_in;
      div_q      <= (div_q == `CCA_DIV6_LAST) ? 3'h0 : div_q + 3'h1;
    end
  end

  // Select count pulse from the mode register source field.
  always_comb begin
    src_sync_q = mode_q[`CCA_MODE_SEL_HI:`CCA_MODE_SEL_LO];
    case (src_sync_q)
      `CCA_SRC_DIV6A:  tick = (div_q == `CCA_DIV6_LAST);
      `CCA_SRC_DIV6B:  tick = (div_q == `CCA_DIV6_LAST);
      `CCA_SRC_TIMER0: tick = timer0_ovf_in & ~t0_prev_q;
      `CCA_SRC_EXT:    tick = ext_sync_q & ~ext_prev_q;
      default:         tick = 1'b0;
    endcase
  end

  assign lo_wrap = run_q & tick & (cnt_lo_q == `CCA_BYTE_MAX);

  // Counter steps only while running; software writes win over counting.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_lo_q <= `CCA_RESET_BYTE;
      cnt_hi_q <= `CCA_RESET_BYTE;
    end else begin
      if (run_q && tick) begin
        cnt_lo_q <= cnt_lo_q + 8'h01;
        if (cnt_lo_q == `CCA_BYTE_MAX) cnt_hi_q <= cnt_hi_q + 8'h01;
      end
      if (write_in && addr_in == `CCA_ADDR_CNT_LO) cnt_lo_q <= wdata_in;
      if (write_in && addr_in == `CCA_ADDR_CNT_HI) cnt_hi_q <= wdata_in;
    end
  end

  // Per-module capture and match events.
  always_comb begin
    for (int m = 0; m < NMOD; m++) begin
      cap_ev[m]   = (bit_of(mmode_q[m], `CCA_MM_RISE) & pin_rise[m])
                  | (bit_of(mmode_q[m], `CCA_MM_FALL) & pin_fall[m]);
      match_ev[m] = bit_of(mmode_q[m], `CCA_MM_CMP) & bit_of(mmode_q[m], `CCA_MM_MATCH)
                  & ({cnt_hi_q, cnt_lo_q} == {cap_hi_q[m], cap_lo_q[m]});
    end
  end

  // Remember the last match so a counter that holds its value toggles a pin only once.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      match_prev_q <= '0;
    end else begin
      match_prev_q <= match_ev;
    end
  end

  // Control register: run bit, overflow flag and module flags.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      run_q      <= 1'b0;
      ovf_flag_q <= 1'b0;
      ev_flag_q  <= '0;
    end else begin
      if (write_in && addr_in == `CCA_ADDR_CTRL) begin
        run_q      <= wdata_in[`CCA_CTRL_RUN];
        ovf_flag_q <= wdata_in[`CCA_CTRL_OVF];
        ev_flag_q  <= wdata_in[NMOD-1:0];
      end
      // Hardware sets win over a same-cycle software clear.
      if (lo_wrap && cnt_hi_q == `CCA_BYTE_MAX) ovf_flag_q <= 1'b1;
      for (int m = 0; m < NMOD; m++) begin
        if (cap_ev[m] || match_ev[m]) ev_flag_q[m] <= 1'b1;
      end
    end
  end

  // Counter mode register holds watchdog enable, source select and overflow enable.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= `CCA_RESET_BYTE;
    end else if (write_in && addr_in == `CCA_ADDR_MODE) begin
      mode_q <= wdata_in & `CCA_MODE_MASK;
    end
  end

  // Module mode registers.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int m = 0; m < NMOD; m++) mmode_q[m] <= `CCA_RESET_BYTE;
    end else begin
      for (int m = 0; m < NMOD; m++) begin
        if (write_in && hit(addr_in, `CCA_ADDR_MMODE0, m)) mmode_q[m] <= wdata_in & `CCA_MM_MASK;
      end
    end
  end

  // Capture pairs: written by software, loaded on capture, low reloaded on wrap in modulation.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int m = 0; m < NMOD; m++) begin
        cap_lo_q[m] <= `CCA_RESET_BYTE;
        cap_hi_q[m] <= `CCA_RESET_BYTE;
      end
    end else begin
      for (int m = 0; m < NMOD; m++) begin
        if (write_in && hit(addr_in, `CCA_ADDR_CAPLO0, m)) cap_lo_q[m] <= wdata_in;
        if (write_in && hit(addr_in, `CCA_ADDR_CAPHI0, m)) cap_hi_q[m] <= wdata_in;
        // Reload only at the wrap so the duty change never cuts a period short.
        if (lo_wrap && bit_of(mmode_q[m], `CCA_MM_PWM)) cap_lo_q[m] <= cap_hi_q[m];
        if (cap_ev[m]) begin
          cap_lo_q[m] <= cnt_lo_q;
          cap_hi_q[m] <= cnt_hi_q;
        end
      end
    end
  end

  // Pin drivers: toggle on match, or modulation compare; capture modes leave the pin undriven.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_q <= '0;
      oe_q  <= '0;
    end else begin
      for (int m = 0; m < NMOD; m++) begin
        if (bit_of(mmode_q[m], `CCA_MM_CMP) && bit_of(mmode_q[m], `CCA_MM_PWM)) begin
          oe_q[m]  <= 1'b1;
          pin_q[m] <= (cnt_lo_q >= cap_lo_q[m]);
        end else if (bit_of(mmode_q[m], `CCA_MM_TOG) && bit_of(mmode_q[m], `CCA_MM_MATCH)
                     && bit_of(mmode_q[m], `CCA_MM_CMP)) begin
          oe_q[m] <= 1'b1;
          if (match_ev[m] && !match_prev_q[m]) pin_q[m] <= ~pin_q[m];
        end else begin
          // Undriven pins keep their last drive level so a later toggle mode starts from it.
          oe_q[m] <= 1'b0;
        end
      end
    end
  end

  // Watchdog: a module 4 match, with the enable set, gives a one-cycle internal reset.
  // Match stays true while the counter holds, so the pulse is issued once per entry.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wst_q  <= cca_pkg::CCA_IDLE;
      wdog_q <= 1'b0;
    end else begin
      case (wst_q)
        cca_pkg::CCA_IDLE: begin
          wdog_q <= 1'b0;
          if (mode_q[`CCA_MODE_WDOG] && match_ev[`CCA_WDOG_MOD]) begin
            wdog_q <= 1'b1;
            wst_q  <= cca_pkg::CCA_PULSE;
          end
        end
        cca_pkg::CCA_PULSE: begin
          wdog_q <= 1'b0;
          if (!match_ev[`CCA_WDOG_MOD]) wst_q <= cca_pkg::CCA_IDLE;
        end
        default: begin
          wdog_q <= 1'b0;
          wst_q  <= cca_pkg::CCA_IDLE;
        end
      endcase
    end
  end

  // Interrupt: module flags gated by their enables, overflow gated by its enable.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (ovf_flag_q & mode_q[`CCA_MODE_OVF_IE]);
      for (int m = 0; m < NMOD; m++) begin
        if (ev_flag_q[m] && bit_of(mmode_q[m], `CCA_MM_IE)) irq_q <= 1'b1;
      end
    end
  end

  // Read data register; unmapped addresses read zero.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= `CCA_RESET_BYTE;
    end else begin
      rdata_q <= `CCA_RESET_BYTE;
      if (read_in) begin
        if (addr_in == `CCA_ADDR_CTRL)
          rdata_q <= {ovf_flag_q, run_q, 1'b0, ev_flag_q} & `CCA_CTRL_MASK;
        if (addr_in == `CCA_ADDR_MODE)   rdata_q <= mode_q;
        if (addr_in == `CCA_ADDR_CNT_LO) rdata_q <= cnt_lo_q;
        if (addr_in == `CCA_ADDR_CNT_HI) rdata_q <= cnt_hi_q;
        for (int m = 0; m < NMOD; m++) begin
          if (hit(addr_in, `CCA_ADDR_MMODE0, m)) rdata_q <= mmode_q[m];
          if (hit(addr_in, `CCA_ADDR_CAPLO0, m)) rdata_q <= cap_lo_q[m];
          if (hit(addr_in, `CCA_ADDR_CAPHI0, m)) rdata_q <= cap_hi_q[m];
        end
      end
    end
  end

  assign rdata_out            = rdata_q;
  assign module_io_pin_out    = pin_q;
  assign module_io_pin_oe_out = oe_q;
  assign irq_out              = irq_q;
  assign wdog_reset_out       = wdog_q;
endmodule : cca_counter_array

// ### verification/cca_checker.sv
`timescale 1ns/1ps
// Port-level checks of the counter array; mode registers are shadowed from register writes.
module cca_checker #(
  parameter int NMOD = 5
) (
  // Clock and reset.
  input  wire logic            clk_in,
  input  wire logic            resetn_in,
  // Register port.
  input  wire logic [4:0]      addr_in,
  input  wire logic [7:0]      wdata_in,
  input  wire logic            write_in,
  input  wire logic            read_in,
  input  wire logic [7:0]      rdata_out,
  // Pins and system outputs.
  input  wire logic [NMOD-1:0] module_io_pin_out,
  input  wire logic            irq_out,
  input  wire logic            wdog_reset_out
);
  logic [7:0] cmode_q;
  logic [7:0] m_q [5];
  logic       ie_any;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  // Shadow copies let gating be judged without looking inside the block.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmode_q <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        m_q[i] <= 8'h00;
      end
    end else if (write_in) begin
      if (addr_in == 5'h01) begin
        cmode_q <= wdata_in;
      end
      if (addr_in >= 5'h04 && addr_in <= 5'h08) begin
        m_q[3'(addr_in - 5'h04)] <= wdata_in;
      end
    end
  end

  // Any interrupt enable at all, counter overflow included.
  assign ie_any = cmode_q[0] | m_q[0][0] | m_q[1][0] | m_q[2][0] | m_q[3][0] | m_q[4][0];

  a_ovf_sticky: assert property (
    write_in && addr_in == 5'h00 && wdata_in[7] ##2 read_in && addr_in == 5'h00 |=> rdata_out[7])
    else $error("overflow flag did not hold after software set");
  a_mode_readback: assert property (
    read_in && addr_in == 5'h01 |=> rdata_out == ($past(cmode_q) & 8'h47))
    else $error("counter mode register read back wrong");
  a_mmode_readback: assert property (
    read_in && addr_in == 5'h04 |=> rdata_out == ($past(m_q[0]) & 8'h7F))
    else $error("module mode register read back wrong");
  a_wdog_one_pulse: assert property (
    wdog_reset_out |=> !wdog_reset_out)
    else $error("internal reset request longer than one cycle");
  a_wdog_gated: assert property (
    !cmode_q[6] && !$past(cmode_q[6]) |-> !wdog_reset_out)
    else $error("internal reset while watchdog disabled");
  a_wdog_mod_four: assert property (
    !m_q[4][6] && !$past(m_q[4][6]) |-> !wdog_reset_out)
    else $error("internal reset without module four comparing");
  a_irq_gated: assert property (
    !ie_any && !$past(ie_any) |-> !irq_out)
    else $error("interrupt request with every enable clear");
  a_pin_idle: assert property (
    m_q[0] == 8'h00 && $past(m_q[0]) == 8'h00 |-> $stable(module_io_pin_out[0]))
    else $error("idle module pin changed");
endmodule : cca_checker

bind cca_counter_array cca_checker #(.NMOD(NMOD)) u_chk (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
  .module_io_pin_out(module_io_pin_out), .irq_out(irq_out), .wdog_reset_out(wdog_reset_out));

// ### verification/cca_pin_model.sv
`timescale 1ns/1ps
// Far side of the module pins; a pin the block drives follows the block.
module cca_pin_model (
  // Clock.
  input  wire logic       clk_in,
  // Block side of the pins.
  input  wire logic [4:0] pin_out_in,
  input  wire logic [4:0] pin_oe_in,
  // Wire level fed back to the block.
  output logic      [4:0] level_out
);
  logic [4:0] ext_q = 5'h00;
  // The block's drive wins, so a driven pin is never fought by the model.
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_q);
  // External levels change just after an edge.
  task automatic set_level(input int idx, input logic v);
    @(posedge clk_in);
    ext_q[idx] <= v;
  endtask : set_level
endmodule : cca_pin_model

// ### verification/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic [4:0] addr_in;
  logic [7:0] wdata_in;
  logic [7:0] rdata_out;
  logic [4:0] pin_in;
  logic [4:0] pin_out;
  logic [4:0] pin_oe;
  logic       clk_in;
  logic       resetn_in;
  logic       write_in;
  logic       read_in;
  logic       timer0_ovf_in;
  logic       irq_out;
  logic       wdog_reset_out;
  int         errors;
  int         cmp_count;
  int         wd_cnt;
  int         cyc;

  cca_counter_array #(.NMOD(5)) dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out), .timer0_ovf_in(timer0_ovf_in),
    .ext_count_in(1'b0), .module_io_pin_in(pin_in), .module_io_pin_out(pin_out),
    .module_io_pin_oe_out(pin_oe), .irq_out(irq_out), .wdog_reset_out(wdog_reset_out));
  cca_pin_model pm (.clk_in(clk_in), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .level_out(pin_in));

  // Free-running clock at 40 MHz.
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Writes from a table of {index, data} entries, one strobe cycle each.
  task automatic wr1(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clk_in);
    write_in <= 1'b0;
  endtask : wr1
  task automatic wl(input logic [11:0] q[$]);
    foreach (q[i]) begin
      wr1({1'b0, q[i][11:8]}, q[i][7:0]);
    end
  endtask : wl
  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= {1'b0, a};
    read_in <= 1'b1;
    @(posedge clk_in);
    read_in <= 1'b0;
    #1;
    `CHK(rdata_out, e)
  endtask : rd
  // Timer0 pulses; the counter holds each value for two clocks.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_in);
      timer0_ovf_in <= 1'b1;
      @(posedge clk_in);
      timer0_ovf_in <= 1'b0;
    end
  endtask : tick
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog pulse counter and hang guard; the run needs well under a thousand cycles.
  always @(posedge clk_in) begin
    cyc++;
    if (wdog_reset_out === 1'b1) begin
      wd_cnt++;
    end
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end

  initial begin
    {addr_in, wdata_in, write_in, read_in, timer0_ovf_in, resetn_in} = '0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(4'h0, 8'h00);
    wl('{12'h104, 12'h040});
    tick(5);
    rd(4'h2, 8'h05);
    wl('{12'h000});
    tick(3);
    rd(4'h2, 8'h05);
    wl('{12'h2FF, 12'h3FF, 12'h040});
    tick(1);
    rd(4'h3, 8'h00);
    rd(4'h0, 8'hC0);
    wl('{12'h040});
    rd(4'h0, 8'h40);
    wl('{12'h000, 12'h080});
    rd(4'h0, 8'h80);
    wl('{12'h105});
    wt(3);
    `CHK(irq_out, 1'b1)
    wl('{12'h000, 12'h104});
    wt(3);
    `CHK(irq_out, 1'b0)
    // Capture on module 0 rising and module 1 falling edges.
    pm.set_level(1, 1'b1);
    wl('{12'h234, 12'h312, 12'h421, 12'h510});
    rd(4'h4, 8'h21);
    pm.set_level(0, 1'b1);
    wt(6);
    rd(4'h9, 8'h34);
    rd(4'hE, 8'h12);
    rd(4'h0, 8'h01);
    `CHK(irq_out, 1'b1)
    wl('{12'h235});
    pm.set_level(1, 1'b0);
    wt(6);
    rd(4'hA, 8'h35);
    wl('{12'h299});
    pm.set_level(0, 1'b0);
    wt(6);
    rd(4'h9, 8'h34);
    rd(4'h0, 8'h03);
    wl('{12'h000, 12'h400, 12'h500});
    wt(3);
    `CHK(irq_out, 1'b0)
    // Software timer on module 2 and toggle output on module 3, both at 0x0040.
    wl('{12'h649, 12'h74C, 12'hB40, 12'hC40, 12'h23E, 12'h300, 12'h040});
    tick(4);
    wt(3);
    rd(4'h0, 8'h4C);
    `CHK(pin_out[3], 1'b1)
    `CHK(irq_out, 1'b1)
    wl('{12'h000, 12'h70C, 12'h23E, 12'h040});
    tick(4);
    wt(3);
    rd(4'h0, 8'h44);
    `CHK(pin_out[3], 1'b1)
    `CHK(pin_oe[3], 1'b0)
    // Modulation on module 1 across the low-byte wrap.
    wl('{12'h000, 12'h600, 12'h700, 12'h542, 12'hA80, 12'hF80, 12'h27E, 12'h040});
    tick(1);
    wt(3);
    `CHK(pin_out[1], 1'b0)
    `CHK(pin_oe[1], 1'b1)
    tick(1);
    wt(3);
    `CHK(pin_out[1], 1'b1)
    wl('{12'hF20, 12'h2FE});
    tick(2);
    wt(3);
    `CHK(pin_out[1], 1'b0)
    rd(4'hA, 8'h20);
    wl('{12'h502});
    wt(3);
    `CHK(pin_oe[1], 1'b0)
    // Watchdog on module 4; the compare value is moved ahead once before it is let match.
    wl('{12'h000, 12'h500, 12'h848, 12'hDF0, 12'h144, 12'h300, 12'h24E, 12'h040});
    tick(4);
    wt(3);
    `CHK(wd_cnt, 0)
    rd(4'h1, 8'h44);
    // Refresh from the main sequence: zero compare low, copy counter high into compare high.
    rd(4'h3, 8'h00);
    wl('{12'hD00});
    wr1(5'h12, 8'h00);
    wl('{12'hD54});
    tick(2);
    wt(3);
    `CHK(wd_cnt, 1)
    wl('{12'h104, 12'hD58});
    tick(4);
    wt(3);
    `CHK(wd_cnt, 1)
    wl('{12'hD5A, 12'h144});
    tick(2);
    wt(3);
    `CHK(wd_cnt, 2)
    tally_and_finish();
  end
endmodule : testbench
